// ==== sim/ropc_link_src.sv ====
/*
 Link side model: recovered pixel clock, pixel word and qualifiers.
 Assumes the caller paces frames; the clock rests low between calls.
*/
`timescale 1ns/1ps
module ropc_link_src (
   output logic rx_pixel_clk,
   output logic [23:0] rx_pixel_data,
   output logic rx_active_video,
   output logic rx_hsync,
   output logic rx_vsync,
   output logic rx_ctrl_1,
   output logic rx_ctrl_2,
   output logic rx_ctrl_3
);
   // Idle link: clock low, qualifier low.
   initial begin
      rx_pixel_clk = 1'b0;
      rx_pixel_data = 24'h000000;
      {rx_active_video, rx_hsync, rx_vsync, rx_ctrl_1, rx_ctrl_2, rx_ctrl_3} = 6'h00;
   end
   // One pixel: 16 ns low with the word set up for the last 8, then 16 ns high.
   // The late set-up leaves the inverse word of the last call on the bus for a
   // while, so the word is never assigned twice in one time step.
   task automatic send(input logic [23:0] px, input logic de);
      #8;
      rx_pixel_data = px;
      rx_active_video = de;
      rx_hsync = ~de;
      rx_vsync = px[8];
      {rx_ctrl_3, rx_ctrl_2, rx_ctrl_1} = px[11:9];
      #8 rx_pixel_clk = 1'b1;
      #16 rx_pixel_clk = 1'b0;
      // Hold time is over: show the inverse so a late sample is caught.
      rx_pixel_data = ~px;
   endtask
endmodule

// ==== sim/ropc_top_monitor.sv ====
/*
 Checker for the receiver output mode and power control block. It sees only
 the top module's ports and is bound to it.
 Assumes the 4 ns sys_clk and straps that are held for many cycles at a time.
*/
`timescale 1ns/1ps
module ropc_top_monitor (
   input wire sys_clk,
   input wire resetn,
   input wire rx_pixel_clk,
   input wire rx_active_video,
   input wire clk_polarity_sel,
   input wire pixels_per_clk_sel,
   input wire link_mode_sel,
   input wire out_powerdown_n,
   input wire full_powerdown_n,
   input wire reserved_in,
   input wire pixel_out_clk,
   input wire pixel_out_clk_oe,
   input wire [23:0] even_data,
   input wire even_data_oe,
   input wire [23:0] odd_data,
   input wire odd_data_oe,
   input wire active_video_qual_oe,
   input wire sync_out_oe,
   input wire general_ctrl_1_oe,
   input wire general_ctrl_23_oe,
   input wire link_alive,
   input wire link_alive_oe,
   input wire analog_powerdown
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   localparam int IDLE = 2500; // Quiet cycles before the alive flag may drop.
   logic [11:0] quiet_reg; // Cycles since the qualifier pin moved, saturating.
   // Counted from the pin, so the synchroniser makes the real drop a bit later.
   always @(posedge sys_clk) begin
      if (!resetn || $changed(rx_active_video)) quiet_reg <= 12'h000;
      else if (quiet_reg != 12'hFFF) quiet_reg <= quiet_reg + 12'h001;
   end
   opd_float_a: assert property (!out_powerdown_n [*4] |-> !(even_data_oe | odd_data_oe |
      pixel_out_clk_oe | active_video_qual_oe | sync_out_oe | general_ctrl_23_oe))
      else $error("outputs still driven in output power down");
   opd_keep_a: assert property ((full_powerdown_n && reserved_in) [*4] |->
      link_alive_oe && general_ctrl_1_oe) else $error("alive flag or control 1 floated");
   fpd_float_a: assert property (!full_powerdown_n [*4] |-> analog_powerdown &&
      !link_alive_oe && !general_ctrl_1_oe && !even_data_oe) else $error("full power down");
   pull_down_a: assert property ((even_data_oe || even_data == 24'h000000) &&
      (odd_data_oe || odd_data == 24'h000000) && (link_alive_oe || !link_alive))
      else $error("floating output not pulled low");
   dual_odd_a: assert property (link_mode_sel [*4] |-> !odd_data_oe)
      else $error("odd bus driven in dual link");
   alive_set_a: assert property ($changed(rx_active_video) && link_alive_oe |->
      ##[1:6] link_alive) else $error("alive flag missed qualifier activity");
   alive_hold_a: assert property ($fell(link_alive) && link_alive_oe |-> quiet_reg >= IDLE)
      else $error("alive flag dropped too early");
   alive_drop_a: assert property (quiet_reg == 12'h9CE && link_alive_oe |-> !link_alive)
      else $error("alive flag stuck high");
   pol_clk_a: assert property (!link_mode_sel && !pixels_per_clk_sel && pixel_out_clk_oe &&
      $past({clk_polarity_sel, pixels_per_clk_sel, link_mode_sel}, 6) ==
      {clk_polarity_sel, pixels_per_clk_sel, link_mode_sel} &&
      $past(rx_pixel_clk, 3) == $past(rx_pixel_clk, 5) &&
      $past(rx_pixel_clk, 4) == $past(rx_pixel_clk, 5) |->
      pixel_out_clk == ($past(rx_pixel_clk, 4) ^ clk_polarity_sel))
      else $error("output clock polarity wrong");
   cover property (link_alive && !out_powerdown_n);
   cover property ($rose(odd_data_oe));
   cover property ($fell(link_alive));
endmodule
bind ropc_top ropc_top_monitor mon (.*);

// ==== sim/ropc_top_test.sv ====
/*
 Self-checking testbench of ropc_top with the link source model.
 Assumes a 250 MHz sys_clk; straps are driven on the falling edge.
*/
`timescale 1ns/1ps
module ropc_top_test;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic clk_polarity_sel = 1'b0, pixels_per_clk_sel = 1'b0, stagger_sel_n = 1'b0;
   logic link_mode_sel = 1'b0, out_powerdown_n = 1'b1, full_powerdown_n = 1'b1;
   logic reserved_in = 1'b1;
   wire rx_pixel_clk, rx_active_video, rx_hsync, rx_vsync, rx_ctrl_1, rx_ctrl_2, rx_ctrl_3;
   wire [23:0] rx_pixel_data, even_data, odd_data;
   wire pixel_out_clk, pixel_out_clk_oe, even_data_oe, odd_data_oe, active_video_qual;
   wire active_video_qual_oe, hsync_out, vsync_out, sync_out_oe, general_ctrl_1;
   wire general_ctrl_1_oe, general_ctrl_2, general_ctrl_3, general_ctrl_23_oe;
   wire link_alive, link_alive_oe, analog_powerdown;
   // Control pins as one word, in the order the notes keep them.
   wire [4:0] ctl_seen = {general_ctrl_3, general_ctrl_2, general_ctrl_1, vsync_out, hsync_out};
   integer failures = 0, n_compared = 0, seed = 54;
   logic [53:0] exp_q[$]; // Notes: control bits, check-odd flag, odd word, even word.
   logic [53:0] item;
   logic [23:0] prev_even = 24'h000000, last_odd = 24'h000000;
   logic odd_known = 1'b0; // Staggered odd bus is unknown right after mode entry.
   logic [7:0] cnt = 8'h00; // Low byte makes every active pixel differ from the last.
   // Mode table: link, width, stagger_n, polarity.
   localparam logic [3:0] MODES [6] = '{4'h0, 4'h3, 4'h6, 4'h5, 4'hC, 4'hA};

   always #2 sys_clk = ~sys_clk;

   ropc_link_src src (.*);
   ropc_top dut (.*);

   // Compares one value and counts it.
   task automatic check(input logic [23:0] seen, input logic [23:0] want);
      n_compared++;
      if (seen !== want) begin
         failures++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic wrap_up;
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // One line: six active pixels, two blank; notes go in before the pixels.
   task automatic send_line(input logic two, input logic stag);
      logic [23:0] px [8];
      // Controls come with the word that loads them: the second of a pair in
      // two pixel mode. Horizontal sync is the inverse qualifier, so low.
      logic [4:0] ctl;
      for (int i = 0; i < 8; i++) begin
         cnt++;
         px[i] = (i < 6) ? {16'($random(seed)), cnt} : 24'h000000;
      end
      for (int i = 0; i < 6; i += two ? 2 : 1) begin
         ctl = {px[two ? i + 1 : i][11:8], 1'b0};
         if (!two) exp_q.push_back({ctl, 25'h0, px[i]});
         else if (!stag) exp_q.push_back({ctl, 1'b1, px[i + 1], px[i]});
         else exp_q.push_back({ctl, odd_known, last_odd, px[i]});
         if (two) last_odd = px[i + 1];
         if (two) odd_known = 1'b1;
      end
      last_odd = 24'h000000;
      for (int i = 0; i < 8; i++) src.send(px[i], i < 6);
   endtask

   // Takes the oldest note whenever a new active pixel shows, mid-cycle.
   always @(negedge sys_clk) begin
      if (even_data_oe && active_video_qual && even_data !== prev_even) begin
         if (exp_q.size() == 0) check(even_data, ~even_data);
         else begin
            item = exp_q.pop_front();
            check(even_data, item[23:0]);
            check(ctl_seen, item[53:49]);
            if (item[48]) check(odd_data, item[47:24]);
         end
      end
      prev_even = even_data;
   end

   // Whole run is near 14.4 us; four times that means a hang.
   initial begin
      #60000;
      failures++;
      $display("ERROR at %0t: watchdog expired", $time);
      wrap_up;
   end

   initial begin
      repeat (2) @(negedge sys_clk);
      resetn = 1'b1;
      for (int m = 0; m < 6; m++) begin
         {link_mode_sel, pixels_per_clk_sel, stagger_sel_n, clk_polarity_sel} = MODES[m];
         odd_known = 1'b0;
         repeat (8) @(negedge sys_clk);
         repeat (2) send_line(pixels_per_clk_sel & !link_mode_sel, !stagger_sel_n);
         repeat (12) @(negedge sys_clk);
         check(24'(exp_q.size()), 24'h000000);
         $display("mode test %0d done", m);
      end
      // The slave is still selected: with its master qualifier low it must
      // show neither the word nor the qualifier.
      stagger_sel_n = 1'b0;
      repeat (4) @(negedge sys_clk);
      src.send(24'h00A5A5, 1'b1);
      check(even_data, 24'h000000);
      check(active_video_qual, 1'b0);
      stagger_sel_n = 1'b1;
      $display("slave sync test done");
      check(link_alive, 1'b1);
      repeat (2600) @(negedge sys_clk);
      check(link_alive, 1'b0);
      $display("alive timeout test done");
      // Feed the dead-link flag back into the pin, as a board may do.
      out_powerdown_n = link_alive;
      repeat (5) @(negedge sys_clk);
      check(even_data_oe, 1'b0);
      check(general_ctrl_1_oe, 1'b1);
      for (int i = 0; i < 8; i++) src.send(24'h00A5A5, i[0]);
      repeat (6) @(negedge sys_clk);
      check(link_alive, 1'b1);
      check(analog_powerdown, 1'b0);
      $display("output power down test done");
      full_powerdown_n = 1'b0;
      repeat (5) @(negedge sys_clk);
      check(link_alive_oe, 1'b0);
      check(general_ctrl_1_oe, 1'b0);
      check(analog_powerdown, 1'b1);
      {full_powerdown_n, out_powerdown_n} = 2'h3;
      repeat (5) @(negedge sys_clk);
      check(pixel_out_clk_oe, 1'b1);
      reserved_in = 1'b0;
      repeat (5) @(negedge sys_clk);
      check(analog_powerdown, 1'b1);
      reserved_in = 1'b1;
      $display("full power down test done");
      wrap_up;
   end
endmodule

// ==== src/ropc_consts.vh ====
/*
 Constants for the receiver output mode and power control block: bus
 widths, bit positions inside the synchronised input bundles, reset
 values and the link-alive timeout.
 Assumes it is included by bare name from the design files.
*/
`ifndef ROPC_CONSTS_VH
`define ROPC_CONSTS_VH

// Width of one pixel bus.
`define ROPC_DATA_W 24

// Positions inside the link bundle (pixel word plus its qualifiers).
`define ROPC_LB_DE 24
`define ROPC_LB_HS 25
`define ROPC_LB_VS 26
`define ROPC_LB_GENERAL_CTRL_1 27
`define ROPC_LB_CTL2 28
`define ROPC_LB_CTL3 29
`define ROPC_LB_CLK 30
`define ROPC_LB_W 31

// Positions inside the strap bundle.
`define ROPC_SB_POL 0
`define ROPC_SB_PPS 1
`define ROPC_SB_STAG_N 2
`define ROPC_SB_MODE 3
`define ROPC_SB_OPD_N 4
`define ROPC_SB_FPD_N 5
`define ROPC_SB_RSVD 6
`define ROPC_SB_W 7

// Reset value of every output and pipeline bit.
`define ROPC_RST_BIT 1'b0
`define ROPC_RST_BUS 24'h000000

// Link-alive timeout: time without a qualifier transition, in ns.
`define ROPC_CLK_PERIOD_NS 4
`define ROPC_DE_IDLE_NS 10000
`define ROPC_DE_IDLE_CYC (`ROPC_DE_IDLE_NS / `ROPC_CLK_PERIOD_NS)

`endif

// ==== src/ropc_sync.v ====
/*
 Two flip-flop synchroniser for a bundle of unrelated level signals.
 Assumes each bit is a level that stays put for several clock cycles;
 bits of one bundle may land one cycle apart.
*/
`timescale 1ns/1ps
module ropc_sync #(
   parameter W = 1
) (
   input wire sys_clk,
   input wire resetn,
   input wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);
   // First stage; read only by the second stage.
   reg [W-1:0] meta_reg;
   // Second stage; the only stage logic may look at.
   reg [W-1:0] stable_reg;

   // Both stages clear on reset so nothing unknown leaks out.
   always @(posedge sys_clk) begin
      if (!resetn) begin
         meta_reg <= {W{1'b0}};
         stable_reg <= {W{1'b0}};
      end else begin
         meta_reg <= async_in;
         stable_reg <= meta_reg;
      end
   end

   assign sync_out = stable_reg;
endmodule

// ==== src/ropc_top.v ====
/*
 Output configuration and power control of a serial video receiver.
 It takes the recovered pixel stream, forms one or two pixels per
 clock, optional staggered drive, dual link master or slave buses,
 the link-alive flag and the two power-down levels.
 Assumes the recovered pixel clock and all strap pins are asynchronous
 to sys_clk and that the pixel clock is well below half of sys_clk.
*/
`timescale 1ns/1ps
`include "ropc_consts.vh"

// Summary of operation
// (RQ1) Polarity pin low passes clock, high inverts.
// (RQ2) Polarity never moves data or control timing.
// (RQ3) Single link: width pin picks one or two.
// (RQ4) Dual link: width pin picks master or slave.
// (RQ5) Stagger pin high simultaneous, low staggered buses.
// (RQ6) Stagger acts only in two pixel mode.
// (RQ7) Slave syncs to master qualifier on stagger pin.
// (RQ8) Link mode pin low single, high dual.
// (RQ9) Link alive high while qualifier toggles.
// (RQ10) Link alive stays driven during output power down.
// (RQ11) Link alive may feed output power down.
// (RQ12) Output power down floats all but two.
// (RQ13) Output power down leaves reception running.
// (RQ14) Full power down floats every output.
// (RQ15) Full power down stops analog and inputs.
// (RQ16) Reserved pin must be held high.
// (RQ17) Dual link master floats its odd bus.
// (RQ18) Slave never enters two pixel mode.
// (RQ19) Full power down overrides output power down.
module ropc_top (
   input wire sys_clk,
   input wire resetn,
   input wire rx_pixel_clk,
   input wire [23:0] rx_pixel_data,
   input wire rx_active_video,
   input wire rx_hsync,
   input wire rx_vsync,
   input wire rx_ctrl_1,
   input wire rx_ctrl_2,
   input wire rx_ctrl_3,
   input wire clk_polarity_sel,
   input wire pixels_per_clk_sel,
   input wire stagger_sel_n,
   input wire link_mode_sel,
   input wire out_powerdown_n,
   input wire full_powerdown_n,
   input wire reserved_in,
   output reg pixel_out_clk,
   output reg pixel_out_clk_oe,
   output reg [23:0] even_data,
   output reg even_data_oe,
   output reg [23:0] odd_data,
   output reg odd_data_oe,
   output reg active_video_qual,
   output reg active_video_qual_oe,
   output reg hsync_out,
   output reg vsync_out,
   output reg sync_out_oe,
   output reg general_ctrl_1,
   output reg general_ctrl_1_oe,
   output reg general_ctrl_2,
   output reg general_ctrl_3,
   output reg general_ctrl_23_oe,
   output reg link_alive,
   output reg link_alive_oe,
   output reg analog_powerdown
);
   // Phases of the pixel pairing in two pixel mode.
   localparam PH_FIRST = 1'b0;
   localparam PH_SECOND = 1'b1;
   // Idle limit in cycles, cut on purpose to the counter width.
   localparam integer IDLE_CYC = `ROPC_DE_IDLE_CYC;
   localparam [11:0] IDLE_LIMIT = IDLE_CYC[11:0];

   // Forces a bus low while its driver is off, as the weak pull-down would.
   function [23:0] drive_bus;
      input [23:0] value;
      input enable;
      begin
         drive_bus = enable ? value : `ROPC_RST_BUS;
      end
   endfunction

   // Same for a single pin.
   function drive_bit;
      input value;
      input enable;
      begin
         drive_bit = enable & value;
      end
   endfunction

   // Synchronised link bundle and strap bundle.
   wire [`ROPC_LB_W-1:0] link_s;
   wire [`ROPC_SB_W-1:0] strap_s;

   // The recovered clock and its data cross together, so they land at most one cycle apart.
   ropc_sync #(
      .W(`ROPC_LB_W)
   ) u_link_sync (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .async_in({rx_pixel_clk, rx_ctrl_3, rx_ctrl_2, rx_ctrl_1, rx_vsync,
                 rx_hsync, rx_active_video, rx_pixel_data}),
      .sync_out(link_s)
   );

   // Strap pins are plain levels from the board.
   ropc_sync #(
      .W(`ROPC_SB_W)
   ) u_strap_sync (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .async_in({reserved_in, full_powerdown_n, out_powerdown_n,
                 link_mode_sel, stagger_sel_n, pixels_per_clk_sel,
                 clk_polarity_sel}),
      .sync_out(strap_s)
   );

   // Decoded configuration.
   wire dual_link = strap_s[`ROPC_SB_MODE]; // RQ8
   wire is_master = strap_s[`ROPC_SB_PPS]; // RQ4
   wire is_slave = dual_link & ~is_master; // RQ4
   // A slave is always dual link, so it can never reach this mode.
   wire two_pix = ~dual_link & strap_s[`ROPC_SB_PPS]; // RQ3 RQ18
   // Stagger only means something in single link two pixel mode.
   wire stagger_on = two_pix & ~strap_s[`ROPC_SB_STAG_N]; // RQ5 RQ6
   // In dual link the stagger pin carries the master qualifier.
   wire master_qual = dual_link & strap_s[`ROPC_SB_STAG_N]; // RQ7
   // A low reserved pin is treated as full power down; it is not a mode.
   wire run = strap_s[`ROPC_SB_FPD_N] & strap_s[`ROPC_SB_RSVD]; // RQ14 RQ16
   // Output power down only gates drivers and never stops reception.
   wire drive_main = run & strap_s[`ROPC_SB_OPD_N]; // RQ12 RQ13 RQ19

   // Link bundle fields.
   wire clk_now = link_s[`ROPC_LB_CLK];
   wire [23:0] pix_now = link_s[23:0];
   wire de_now = link_s[`ROPC_LB_DE];

   // Previous clock level, for edge finding.
   reg clk_prev_reg;
   // Previous qualifier level, for activity detection.
   reg de_prev_reg;
   // Cycles since the last qualifier transition.
   reg [11:0] idle_cnt_reg;
   // Internal link-alive state.
   reg alive_reg;
   // Pairing phase in two pixel mode.
   reg phase_reg;
   // First pixel of a pair waiting for its partner.
   reg [23:0] hold_reg;
   // Odd pixel waiting for the staggered half period.
   reg [23:0] odd_wait_reg;
   // Set while odd_wait_reg holds a pixel not yet shown.
   reg odd_pend_reg;
   // Internal bus values before the output stage.
   reg [23:0] even_int_reg;
   reg [23:0] odd_int_reg;
   // Internal control values before the output stage.
   reg de_int_reg;
   reg hs_int_reg;
   reg vs_int_reg;
   reg general_ctrl_1_int_reg;
   reg ctl2_int_reg;
   reg ctl3_int_reg;
   // Output clock before polarity.
   reg base_clk_reg;

   // A pixel arrives on each rising edge of the recovered clock.
   wire rise = clk_now & ~clk_prev_reg;
   // Control and even data move once per output clock.
   wire load_out = rise & (~two_pix | (phase_reg == PH_SECOND));

   // Activity detector: any qualifier transition restarts the timeout.
   // The transition is tested first, so an edge in the timeout cycle wins.
   always @(posedge sys_clk) begin
      if (!resetn) begin
         de_prev_reg <= `ROPC_RST_BIT;
         idle_cnt_reg <= 12'h000;
         alive_reg <= `ROPC_RST_BIT;
      end else if (!run) begin
         // Inputs are disabled, so the link reads as down.
         de_prev_reg <= `ROPC_RST_BIT; // RQ15
         idle_cnt_reg <= 12'h000;
         alive_reg <= `ROPC_RST_BIT;
      end else begin
         de_prev_reg <= de_now;
         if (de_now != de_prev_reg) begin
            idle_cnt_reg <= 12'h000; // RQ9
            alive_reg <= 1'b1; // RQ9
         end else if (idle_cnt_reg == IDLE_LIMIT - 12'h001) begin
            alive_reg <= 1'b0; // RQ9
         end else begin
            idle_cnt_reg <= idle_cnt_reg + 12'h001;
         end
      end
   end

   // Pixel pipeline: edge finding, pairing, staggering and slave gating.
   always @(posedge sys_clk) begin
      if (!resetn || !run) begin
         // Full power down clears the pipeline like a reset.
         clk_prev_reg <= `ROPC_RST_BIT; // RQ15
         phase_reg <= PH_FIRST;
         hold_reg <= `ROPC_RST_BUS;
         odd_wait_reg <= `ROPC_RST_BUS;
         odd_pend_reg <= `ROPC_RST_BIT;
         even_int_reg <= `ROPC_RST_BUS;
         odd_int_reg <= `ROPC_RST_BUS;
         de_int_reg <= `ROPC_RST_BIT;
         hs_int_reg <= `ROPC_RST_BIT;
         vs_int_reg <= `ROPC_RST_BIT;
         general_ctrl_1_int_reg <= `ROPC_RST_BIT;
         ctl2_int_reg <= `ROPC_RST_BIT;
         ctl3_int_reg <= `ROPC_RST_BIT;
         base_clk_reg <= `ROPC_RST_BIT;
      end else begin
         clk_prev_reg <= clk_now;
         // In one pixel mode the output clock follows the link clock.
         if (!two_pix) begin
            base_clk_reg <= clk_now;
            phase_reg <= PH_FIRST;
            odd_pend_reg <= 1'b0;
         end
         if (rise && two_pix) begin
            case (phase_reg)
               PH_FIRST: begin
                  hold_reg <= pix_now; // RQ3
                  phase_reg <= PH_SECOND;
                  base_clk_reg <= 1'b0;
                  // The staggered odd pixel appears half a period late.
                  if (odd_pend_reg) begin
                     odd_int_reg <= odd_wait_reg; // RQ5
                     odd_pend_reg <= 1'b0;
                  end
               end
               PH_SECOND: begin
                  even_int_reg <= hold_reg; // RQ3
                  phase_reg <= PH_FIRST;
                  base_clk_reg <= 1'b1;
                  if (stagger_on) begin
                     odd_wait_reg <= pix_now; // RQ5 RQ6
                     odd_pend_reg <= 1'b1;
                  end else begin
                     odd_int_reg <= pix_now; // RQ5
                  end
               end
               default: begin
                  phase_reg <= PH_FIRST;
               end
            endcase
         end else if (rise) begin
            // One pixel per clock; a slave shows data only under the
            // master qualifier, so both halves of a line start together.
            if (is_slave) begin
               even_int_reg <= master_qual ? pix_now : `ROPC_RST_BUS; // RQ7
            end else begin
               even_int_reg <= pix_now; // RQ3
            end
            odd_int_reg <= `ROPC_RST_BUS;
         end
         // Control moves with the even bus in every mode.
         if (load_out) begin
            de_int_reg <= de_now & (~is_slave | master_qual); // RQ7
            hs_int_reg <= link_s[`ROPC_LB_HS];
            vs_int_reg <= link_s[`ROPC_LB_VS];
            general_ctrl_1_int_reg <= link_s[`ROPC_LB_GENERAL_CTRL_1];
            ctl2_int_reg <= link_s[`ROPC_LB_CTL2];
            ctl3_int_reg <= link_s[`ROPC_LB_CTL3];
         end
      end
   end

   // Enables: a slave's even bus stays off while its own link is down, and a dual
   // link master leaves its odd bus to the slave.
   wire even_en = drive_main & (~is_slave | alive_reg);
   wire odd_en = drive_main & ~dual_link; // RQ17

   // Output stage: every pin leaves from a flop, one cycle after the
   // internal values. The clock shares this stage, so its polarity
   // choice cannot skew data against control.
   always @(posedge sys_clk) begin
      if (!resetn) begin
         pixel_out_clk <= `ROPC_RST_BIT;
         pixel_out_clk_oe <= `ROPC_RST_BIT;
         even_data <= `ROPC_RST_BUS;
         even_data_oe <= `ROPC_RST_BIT;
         odd_data <= `ROPC_RST_BUS;
         odd_data_oe <= `ROPC_RST_BIT;
         active_video_qual <= `ROPC_RST_BIT;
         active_video_qual_oe <= `ROPC_RST_BIT;
         hsync_out <= `ROPC_RST_BIT;
         vsync_out <= `ROPC_RST_BIT;
         sync_out_oe <= `ROPC_RST_BIT;
         general_ctrl_1 <= `ROPC_RST_BIT;
         general_ctrl_1_oe <= `ROPC_RST_BIT;
         general_ctrl_2 <= `ROPC_RST_BIT;
         general_ctrl_3 <= `ROPC_RST_BIT;
         general_ctrl_23_oe <= `ROPC_RST_BIT;
         link_alive <= `ROPC_RST_BIT;
         link_alive_oe <= `ROPC_RST_BIT;
         analog_powerdown <= `ROPC_RST_BIT;
      end else begin
         // Only the clock sees the polarity select.
         pixel_out_clk <= drive_bit(base_clk_reg ^ strap_s[`ROPC_SB_POL],
                                    drive_main); // RQ1 RQ2
         pixel_out_clk_oe <= drive_main; // RQ12
         even_data <= drive_bus(even_int_reg, even_en); // RQ12
         even_data_oe <= even_en; // RQ12
         odd_data <= drive_bus(odd_int_reg, odd_en); // RQ17
         odd_data_oe <= odd_en; // RQ17
         active_video_qual <= drive_bit(de_int_reg, drive_main); // RQ2
         active_video_qual_oe <= drive_main; // RQ12
         hsync_out <= drive_bit(hs_int_reg, drive_main);
         vsync_out <= drive_bit(vs_int_reg, drive_main);
         sync_out_oe <= drive_main; // RQ12
         general_ctrl_2 <= drive_bit(ctl2_int_reg, drive_main);
         general_ctrl_3 <= drive_bit(ctl3_int_reg, drive_main);
         general_ctrl_23_oe <= drive_main; // RQ12
         // These two ignore output power down; only full power down stops them.
         general_ctrl_1 <= drive_bit(general_ctrl_1_int_reg, run); // RQ12 RQ19
         general_ctrl_1_oe <= run; // RQ19
         link_alive <= drive_bit(alive_reg, run); // RQ10 RQ19
         link_alive_oe <= run; // RQ10 RQ14
         // Tells the analog front end to shut down.
         analog_powerdown <= ~run; // RQ15
      end
   end
endmodule
